// ---- hdl/front_panel_status_logic.sv ----
`timescale 1ns/1ps
`default_nettype none
module front_panel_status_logic
    import fp_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYCLES_DEF
) (
    input wire logic clk, // local bus clock, 100 MHz
    input wire logic reset_n, // async board reset, active low
    // apb slave
    input wire logic psel, // slave select
    input wire logic penable, // access phase
    input wire logic pwrite, // write when high
    input wire logic [ADDR_W-1:0] paddr, // byte address
    input wire logic [31:0] pwdata, // write data
    output logic [31:0] prdata, // read data
    output logic pready, // always ready
    output logic pslverr, // unmapped address
    // front panel pushbuttons
    input wire logic reset_button_n, // raw, low while pressed
    input wire logic abort_button_n, // raw, low while pressed
    // board state
    input wire logic board_fail_line, // board failure, high active
    input wire logic [CPU_ST_W-1:0] cpu_status, // processor status
    input wire logic transfer_in_progress_n, // low during a cycle
    input wire logic sys_controller, // board is system controller
    input wire logic vme_as_out, // interface drives address strobe
    input wire logic [NMASTER-1:0] lb_req, // local bus requests
    output logic [NMASTER-1:0] lb_grant, // one-hot local bus grant, all zero when nobody requests between cycles
    // resets
    output logic board_reset_n, // resets all onboard devices
    output logic sysreset_o, // backplane reset level, always 0
    output logic sysreset_oe_n, // low while pulling sysreset
    // interrupt
    output logic irq, // level, unmasked status pending
    output logic [LVL_W-1:0] abort_irq_level, // programmed level
    // lamps
    output logic fail_lamp, // red
    output logic stat_lamp, // yellow
    output logic run_lamp, // green
    output logic sys_controller_lamp, // green
    output logic lan_lamp, // green
    output logic scsi_lamp, // green
    output logic vme_lamp // green
);

    // every flop of the block sits in this one struct; the comb block
    // works out next_st and a single clocked block stores it, so no
    // field can pick up a second writer by accident
    typedef struct packed {
        logic [1:0] fail_sync; // board-fail synchroniser
        logic [CTRL_W-1:0] ctrl; // enables and abort level
        logic [EV_W-1:0] status; // sticky events
        logic [EV_W-1:0] mask; // interrupt mask
        logic [EV_W-1:0] rd_clr; // status bits reported by a read
        logic [31:0] rdata; // read data captured at setup
        logic slverr; // unmapped access flag
        logic [NMASTER-1:0] grant; // current local bus owner
        logic [LAMP_W-1:0] lamps; // lamp drive
        logic [RST_CNT_W-1:0] rst_cnt; // reset pulse timer
        logic rst_active; // board reset being driven
        logic sysrst_drive; // backplane reset being driven
    } fp_s;

    fp_s st;
    fp_s next_st;

    // filtered pushbuttons, one debouncer per button
    // the contacts are asynchronous to clk and bounce for a long time,
    // so each one goes through its own synchroniser and settle timer;
    // the cost is a press latency of the full settle time
    debounce_if btn [NBTN] ();
    logic [NBTN-1:0] btn_pin_n;
    logic [NBTN-1:0] btn_press;

    assign btn_pin_n[BTN_RESET] = reset_button_n;
    assign btn_pin_n[BTN_ABORT] = abort_button_n;

    genvar gi;
    generate
        for (gi = 0; gi < NBTN; gi++) begin : g_btn
            button_debounce #(
                .SETTLE_CYCLES(DEBOUNCE_CYCLES)
            ) u_deb (
                .clk(clk),
                .reset_n(reset_n),
                .button_n(btn_pin_n[gi]),
                .btn(btn[gi])
            );
            assign btn_press[gi] = btn[gi].press;
        end
    endgenerate

    // fixed-priority pick: lowest index that requests wins
    // the index order is ethernet, scsi, backplane, processor, so a
    // plain first-set search gives the fixed ranking; the processor
    // only wins the bus when no dma master is asking for it
    function automatic logic [NMASTER-1:0] prio_pick(
        input logic [NMASTER-1:0] req
    );
        logic [NMASTER-1:0] g;
        logic found;
        g = '0;
        found = 1'b0;
        for (int i = 0; i < NMASTER; i++) begin
            if (req[i] && !found) begin
                g[i] = 1'b1;
                found = 1'b1;
            end
        end
        return g;
    endfunction

    // register hit test, used by both apb phases
    // kept as a function so setup, access and the hole check all
    // compare addresses the same way
    function automatic logic is_reg(
        input logic [ADDR_W-1:0] a,
        input logic [7:0] ofs
    );
        return a == ofs;
    endfunction

    // apb phase decode
    // pready is tied high, so every access ends on its first access
    // edge; read data is captured one edge earlier, at setup, which
    // keeps prdata on a flop at the price of a copy of each register
    logic setup_ph;
    logic access_ph;
    logic mapped;
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign mapped = is_reg(paddr, OFS_CTRL) || is_reg(paddr, OFS_STATUS)
        || is_reg(paddr, OFS_MASK) || is_reg(paddr, OFS_LAMPS);

    // events raised this cycle
    // presses arrive as one-cycle pulses from the debouncers; gating
    // them with the enables here means a disabled button never gets
    // as far as the reset timer or the abort status bit
    logic ev_abort;
    logic ev_rst_take;
    logic ev_rst_blocked;
    logic [EV_W-1:0] ev;
    assign ev_abort = btn_press[BTN_ABORT] && st.ctrl[CTRL_ABORT_EN];
    assign ev_rst_take = btn_press[BTN_RESET] && st.ctrl[CTRL_RST_EN];
    // a press while disabled only leaves a note for software
    assign ev_rst_blocked = btn_press[BTN_RESET] && !st.ctrl[CTRL_RST_EN];

    // event strobes packed in status bit order
    always_comb begin
        ev = '0;
        ev[EV_ABORT] = ev_abort;
        ev[EV_RST_BLOCKED] = ev_rst_blocked;
    end

    // next-state logic
    // one comb block for all fields; every field starts from its
    // current value, so a field nobody touches simply holds
    always_comb begin
        next_st = st;

        // board-fail comes from outside, two flops before use
        next_st.fail_sync = {st.fail_sync[0], board_fail_line};

        // setup phase: capture read data and error so they come from flops
        if (setup_ph) begin
            next_st.slverr = !mapped;
            next_st.rdata = '0;
            next_st.rd_clr = '0;
            if (!pwrite) begin
                if (is_reg(paddr, OFS_CTRL)) begin
                    next_st.rdata[CTRL_W-1:0] = st.ctrl;
                end else if (is_reg(paddr, OFS_STATUS)) begin
                    next_st.rdata[EV_W-1:0] = st.status;
                    // remember what was reported, clear only that
                    next_st.rd_clr = st.status;
                end else if (is_reg(paddr, OFS_MASK)) begin
                    next_st.rdata[EV_W-1:0] = st.mask;
                end else if (is_reg(paddr, OFS_LAMPS)) begin
                    next_st.rdata[LAMP_W-1:0] = st.lamps;
                    next_st.rdata[LAMP_GNT_LSB +: NMASTER] = st.grant;
                end else begin
                    next_st.rdata = '0; // unmapped reads as zero
                end
            end
        end

        // sticky status: a new event wins over the read clear
        // rd_clr holds only the bits that the setup cycle reported, so an
        // event that lands between setup and access stays pending and is
        // seen on the next read instead of being lost
        next_st.status = st.status | ev;
        if (access_ph && !pwrite && is_reg(paddr, OFS_STATUS)) begin
            next_st.status = (st.status & ~st.rd_clr) | ev;
        end

        // writes land at the access edge only
        // a write in setup alone changes nothing; status and lamps are
        // read only, so writes to them are dropped here
        if (access_ph && pwrite) begin
            if (is_reg(paddr, OFS_CTRL)) begin
                next_st.ctrl = pwdata[CTRL_W-1:0];
            end else if (is_reg(paddr, OFS_MASK)) begin
                next_st.mask = pwdata[EV_W-1:0];
            end else begin
                next_st.mask = st.mask; // status, lamps and holes ignore it
            end
        end

        // reset pushbutton: timed board reset, backplane too if controller
        // the timer restarts on each accepted press; the backplane line
        // is only pulled when the board held the controller role at the
        // moment of the press, and is released with the board reset
        if (ev_rst_take) begin
            next_st.rst_active = 1'b1;
            next_st.sysrst_drive = sys_controller;
            next_st.rst_cnt = RST_CNT_W'(RESET_PULSE_CYCLES - 1);
        end else if (st.rst_active) begin
            if (st.rst_cnt == '0) begin
                next_st.rst_active = 1'b0;
                next_st.sysrst_drive = 1'b0;
            end else begin
                next_st.rst_cnt = st.rst_cnt - 1'b1;
            end
        end

        // local bus arbiter: re-arbitrate only between bus cycles, so
        // an owner is never pre-empted in the middle of a burst
        // limitation: a master that never ends its cycle starves the rest
        if (transfer_in_progress_n) begin
            next_st.grant = prio_pick(lb_req);
        end

        // lamp drive
        // lamps are registered so they never glitch on a combinational
        // path; the master lamps read the registered grant and so trail
        // it by one more cycle, which nobody can see on a panel
        next_st.lamps[LAMP_FAIL] = st.fail_sync[1];
        next_st.lamps[LAMP_STAT] = cpu_status == CPU_ST_HALT;
        next_st.lamps[LAMP_RUN] = !transfer_in_progress_n;
        next_st.lamps[LAMP_SYS_CONTROLLER_LAMP] = sys_controller;
        next_st.lamps[LAMP_LAN] = st.grant[M_ETH];
        next_st.lamps[LAMP_SCSI] = st.grant[M_SCSI];
        // backplane in use either as requester or as responder
        next_st.lamps[LAMP_VME] = vme_as_out || st.grant[M_VME];
    end

    // state register; everything resets to constants
    // the reset branch names each field so that the enables come up
    // at their reset values; only constants are loaded here, the
    // asynchronous reset must not depend on any other signal
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st.fail_sync <= '0;
            st.ctrl <= CTRL_RESET;
            st.status <= '0;
            st.mask <= MASK_RESET;
            st.rd_clr <= '0;
            st.rdata <= '0;
            st.slverr <= 1'b0;
            st.grant <= '0;
            st.lamps <= '0;
            st.rst_cnt <= '0;
            st.rst_active <= 1'b0;
            st.sysrst_drive <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // apb answers in the first access cycle
    // pslverr is only shown in the access phase; outside a transfer
    // the stored flag is hidden
    assign pready = 1'b1;
    assign prdata = st.rdata;
    assign pslverr = st.slverr && access_ph;

    // local bus grant
    // the grant is a flop, so a requester sees it one edge later
    assign lb_grant = st.grant;

    // reset outputs; the backplane line is open drain, drive only low
    // the level output is tied low and only the enable moves, so the
    // shared backplane line is either pulled low or left to its
    // pull-up; the enable is low while the line is driven
    assign board_reset_n = !st.rst_active;
    assign sysreset_o = 1'b0;
    assign sysreset_oe_n = !st.sysrst_drive;

    // interrupt: level while any unmasked sticky bit is set
    // the mask gates the output only; status bits still collect
    // while masked, so software can poll them
    assign irq = |(st.status & st.mask);
    assign abort_irq_level = st.ctrl[CTRL_LVL_LSB +: LVL_W];

    // lamps straight from flops
    // one flop per lamp drives each pin directly; the lamp bits in
    // the lamps register read the very same flops
    assign fail_lamp = st.lamps[LAMP_FAIL];
    assign stat_lamp = st.lamps[LAMP_STAT];
    assign run_lamp = st.lamps[LAMP_RUN];
    assign sys_controller_lamp = st.lamps[LAMP_SYS_CONTROLLER_LAMP];
    assign lan_lamp = st.lamps[LAMP_LAN];
    assign scsi_lamp = st.lamps[LAMP_SCSI];
    assign vme_lamp = st.lamps[LAMP_VME];
endmodule
`default_nettype wire

// ---- include/fp_pkg.sv ----
// Functional notes
// - enabled reset press resets whole board
// - reset press drives sysreset when system controller
// - software can disable reset pushbutton
// - enabled abort press interrupts at programmed level
// - fail lamp follows board-fail line
// - status lamp lit on decoded processor halt
// - run lamp lit while transfer-in-progress low
// - system-controller lamp follows controller role
// - network lamp lit while ethernet granted
// - scsi lamp lit while scsi granted
// - backplane lamp on strobe out or backplane granted
// - fixed priority: ethernet, scsi, backplane, processor
// - local bus is 32-bit synchronous burst bus
package fp_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 10;
    // pushbutton debounce: least settle time, rounded up
    localparam int DEBOUNCE_US = 10000;
    localparam int DEBOUNCE_CYCLES_DEF =
        (DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // board reset pulse: least width, rounded up
    localparam int RESET_PULSE_NS = 1000;
    localparam int RESET_PULSE_CYCLES =
        (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = $clog2(RESET_PULSE_CYCLES + 1);
    // apb register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_LAMPS = 8'h0c;
    // control register fields
    localparam int CTRL_RST_EN = 0;
    localparam int CTRL_ABORT_EN = 1;
    localparam int CTRL_LVL_LSB = 2;
    localparam int LVL_W = 3;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RESET = 5'h01;
    // status / mask fields
    localparam int EV_ABORT = 0;
    localparam int EV_RST_BLOCKED = 1;
    localparam int EV_W = 2;
    localparam logic [1:0] MASK_RESET = 2'h0;
    // lamp bits in the lamps register
    localparam int LAMP_FAIL = 0;
    localparam int LAMP_STAT = 1;
    localparam int LAMP_RUN = 2;
    localparam int LAMP_SYS_CONTROLLER_LAMP = 3;
    localparam int LAMP_LAN = 4;
    localparam int LAMP_SCSI = 5;
    localparam int LAMP_VME = 6;
    localparam int LAMP_W = 7;
    localparam int LAMP_GNT_LSB = 8;
    // local bus masters, index 0 is the highest priority
    localparam int M_ETH = 0;
    localparam int M_SCSI = 1;
    localparam int M_VME = 2;
    localparam int M_CPU = 3;
    localparam int NMASTER = 4;
    // processor status decode
    localparam int CPU_ST_W = 2;
    localparam logic [1:0] CPU_ST_HALT = 2'h3;
    // pushbutton indexes
    localparam int BTN_RESET = 0;
    localparam int BTN_ABORT = 1;
    localparam int NBTN = 2;
endpackage

// ---- include/debounce_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// filtered pushbutton state handed from a debouncer to its user
interface debounce_if;
    logic pressed; // debounced level, high while held
    logic press; // one-cycle pulse on each new press
    modport filt (output pressed, output press);
    modport user (input pressed, input press);
endinterface
`default_nettype wire

// ---- hdl/button_debounce.sv ----
`timescale 1ns/1ps
`default_nettype none
module button_debounce
    import fp_pkg::*;
#(
    parameter int SETTLE_CYCLES = DEBOUNCE_CYCLES_DEF
) (
    input wire logic clk, // local bus clock
    input wire logic reset_n, // async reset, active low
    input wire logic button_n, // raw pin, low while pressed
    debounce_if.filt btn // filtered result
);
    localparam int CW = $clog2(SETTLE_CYCLES + 1);

    typedef struct packed {
        logic [1:0] sync; // two-stage synchroniser
        logic stable; // accepted pressed level
        logic [CW-1:0] count; // time the raw level has differed
        logic press; // new press pulse
    } deb_s;

    deb_s st;
    deb_s next_st;

    // only the second stage is looked at, never the first
    always_comb begin
        next_st = st;
        next_st.sync = {st.sync[0], ~button_n};
        next_st.press = 1'b0;
        if (st.sync[1] == st.stable) begin
            next_st.count = '0; // bounce seen, restart the wait
        end else if (st.count == CW'(SETTLE_CYCLES - 1)) begin
            // level held long enough: accept it, one event per press
            next_st.stable = st.sync[1];
            next_st.press = st.sync[1];
            next_st.count = '0;
        end else begin
            next_st.count = st.count + 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign btn.pressed = st.stable;
    assign btn.press = st.press;
endmodule
`default_nettype wire

// ---- tb/fp_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module fp_asserts
    import fp_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYCLES_DEF // filter length
) (
    input wire logic clk, // local bus clock
    input wire logic reset_n, // async reset, active low
    input wire logic transfer_in_progress_n, // low during a cycle
    input wire logic [NMASTER-1:0] lb_req, // bus requests
    input wire logic [NMASTER-1:0] lb_grant, // bus grant
    input wire logic board_reset_n, // board reset pulse
    input wire logic sysreset_o, // backplane reset level
    input wire logic sysreset_oe_n, // backplane reset enable
    input wire logic board_fail_line, // failure input
    input wire logic [CPU_ST_W-1:0] cpu_status, // processor status
    input wire logic sys_controller, // controller role
    input wire logic vme_as_out, // strobe driven
    input wire logic fail_lamp, // red
    input wire logic stat_lamp, // yellow
    input wire logic run_lamp, // green
    input wire logic sys_controller_lamp, // green
    input wire logic lan_lamp, // green
    input wire logic scsi_lamp, // green
    input wire logic vme_lamp // green
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [7:0] low_len; // length of the current reset pulse
    // count low cycles so the pulse width is checked on its rising edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            low_len <= 8'h00;
        end else begin
            low_len <= board_reset_n ? 8'h00 : low_len + 8'h01;
        end
    end
    // inputs held long enough to pass the synchronisers
    sequence fail_held; board_fail_line [*6]; endsequence
    sequence halt_held; (cpu_status == CPU_ST_HALT) [*4]; endsequence
    grant_onehot_a: assert property ($onehot0(lb_grant))
        else $error("grant not one-hot");
    eth_first_a: assert property (transfer_in_progress_n &&
        lb_req[M_ETH] |=> lb_grant == 4'h1) else $error("eth not first");
    scsi_next_a: assert property (transfer_in_progress_n &&
        lb_req[1:0] == 2'h2 |=> lb_grant == 4'h2)
        else $error("scsi not second");
    grant_hold_a: assert property (!transfer_in_progress_n
        |=> $stable(lb_grant)) else $error("grant moved in cycle");
    run_lamp_a: assert property ($fell(transfer_in_progress_n)
        |=> run_lamp) else $error("run lamp dark");
    master_lamps_a: assert property ({scsi_lamp, lan_lamp} ==
        $past(lb_grant[1:0])) else $error("master lamp wrong");
    sys_controller_lamp_lamp_a: assert property ($rose(sys_controller)
        |-> ##[1:3] sys_controller_lamp) else $error("sys_controller_lamp lamp dark");
    fail_lamp_a: assert property (fail_held |-> fail_lamp)
        else $error("fail lamp dark");
    stat_lamp_a: assert property (halt_held |-> stat_lamp)
        else $error("status lamp dark");
    vme_lamp_a: assert property (vme_as_out [*4] |-> vme_lamp)
        else $error("vme lamp dark");
    reset_width_a: assert property ($rose(board_reset_n)
        |-> low_len == 8'(RESET_PULSE_CYCLES)) else $error("pulse width");
    sysreset_a: assert property (!sysreset_oe_n |->
        !board_reset_n && !sysreset_o) else $error("sysreset alone");
endmodule
bind front_panel_status_logic fp_asserts #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) chk (.*);
`default_nettype wire

// ---- tb/panel_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module panel_model #(
    parameter int HOLD = 40 // cycles each settled contact state is held; chatter states last one cycle
) (
    input wire logic clk, // local bus clock
    output logic reset_button_n, // low while pressed
    output logic abort_button_n // low while pressed
);
    logic [1:0] pin_n = 2'h3; // raw contacts, open at start
    assign reset_button_n = pin_n[0];
    assign abort_button_n = pin_n[1];
    // contacts chatter on make and break; the filter must swallow it
    task press(input int b);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            pin_n[b] <= i[0];
        end
        repeat (HOLD) @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            pin_n[b] <= ~i[0];
        end
        repeat (HOLD) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
    n_mismatch++; $display("CHECK FAILED t=%0t got %h exp %h", \
    $time, (a), (b)); end end
module testbench;
    import fp_pkg::*;
    localparam int DEB = 8; // short filter keeps presses cheap
    logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, err, reset_button_n, abort_button_n;
    logic board_fail_line = 0, sys_controller = 0, vme_as_out = 0;
    logic transfer_in_progress_n = 1;
    logic [1:0] cpu_status = 0;
    logic [3:0] lb_req = 0, lb_grant, r, e;
    logic board_reset_n, sysreset_o, sysreset_oe_n, irq;
    logic fail_lamp, stat_lamp, run_lamp, sys_controller_lamp;
    logic lan_lamp, scsi_lamp, vme_lamp;
    logic [2:0] abort_irq_level, l;
    logic [4:0] v;
    int n_mismatch = 0, cmp_count = 0;
    integer low_cnt = 0, oe_cnt = 0; // four-state, so an unknown shows
    integer low0 = 0, oe0 = 0; // counts when a press began
    logic [6:0] lamp_vec; // lamps in the lamps register order
    assign lamp_vec = {vme_lamp, scsi_lamp, lan_lamp, sys_controller_lamp,
        run_lamp, stat_lamp, fail_lamp};
    int seed = 32'h3bad63cc;
    front_panel_status_logic #(.DEBOUNCE_CYCLES(DEB)) dut (.*);
    panel_model #(.HOLD(40)) pm (.*);
    always #5 clk = ~clk;
    // falling edge sampling keeps pulse counts free of races
    always @(negedge clk) begin
        low_cnt += !board_reset_n;
        oe_cnt += !sysreset_oe_n;
    end
    function automatic logic [3:0] prio(input logic [3:0] rq);
        prio = 4'h0;
        for (int i = 3; i >= 0; i--) if (rq[i]) prio = 4'h1 << i;
    endfunction
    // lamps for a lamp-test vector while no master is granted
    function automatic logic [6:0] exp_lamps(input logic [4:0] vv);
        exp_lamps = {vv[2], 2'b00, vv[3], ~vv[4], vv[1], vv[0]};
    endfunction
    // one apb transfer; pready is awaited, never assumed
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task push(input int b);
        low0 = low_cnt;
        oe0 = oe_cnt;
        pm.press(b);
        repeat (120) @(posedge clk);
        #1;
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // cut a hang short well past the expected run length
    initial begin
        #200000;
        n_mismatch++;
        summarize;
    end
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1;
        apb(0, OFS_CTRL, 0);
        `CHK(q, 32'h1)
        apb(0, 8'h10, 0);
        `CHK({err, q}, 33'h100000000)
        $display("register test done");
        repeat (40) begin
            r = 4'($random(seed));
            e = prio(r);
            @(posedge clk);
            {lb_req, transfer_in_progress_n} <= {r, 1'b1};
            @(posedge clk);
            {lb_req, transfer_in_progress_n} <= {~r, 1'b0};
            #1 `CHK(lb_grant, e)
            repeat (2) @(posedge clk);
            #1 `CHK(lb_grant, e)
            `CHK(lamp_vec[6:4], e[2:0])
            `CHK(run_lamp, 1'b1)
        end
        $display("arbiter test done");
        @(posedge clk);
        {lb_req, transfer_in_progress_n} <= 5'h01;
        repeat (20) begin
            v = 5'($random(seed));
            @(posedge clk);
            board_fail_line <= v[0];
            cpu_status <= v[1] ? CPU_ST_HALT : {1'b0, v[4]};
            {sys_controller, vme_as_out} <= v[3:2];
            transfer_in_progress_n <= v[4];
            repeat (6) @(posedge clk);
            #1 `CHK(lamp_vec, exp_lamps(v))
            apb(0, OFS_LAMPS, 0);
            `CHK(q, {25'h0, exp_lamps(v)})
        end
        $display("lamp test done");
        for (int sc = 1; sc >= 0; sc--) begin
            @(posedge clk);
            sys_controller <= sc[0];
            push(BTN_RESET);
            `CHK(low_cnt - low0, RESET_PULSE_CYCLES)
            `CHK(oe_cnt - oe0, sc * RESET_PULSE_CYCLES)
        end
        apb(1, OFS_CTRL, 0);
        push(BTN_RESET);
        `CHK(low_cnt - low0, 0)
        `CHK(oe_cnt - oe0, 0)
        apb(0, OFS_STATUS, 0);
        `CHK(q, 32'h2)
        $display("reset button test done");
        apb(1, OFS_MASK, 1);
        apb(0, OFS_MASK, 0);
        `CHK(q, 32'h1)
        push(BTN_ABORT);
        `CHK(irq, 1'b0)
        l = 3'($random(seed));
        apb(1, OFS_CTRL, {27'h0, l, 2'b10});
        push(BTN_ABORT);
        `CHK({irq, abort_irq_level}, {1'b1, l})
        apb(0, OFS_STATUS, 0);
        `CHK(q, 32'h1)
        @(posedge clk);
        #1 `CHK(irq, 1'b0)
        apb(1, OFS_MASK, 0);
        push(BTN_ABORT);
        `CHK(irq, 1'b0)
        apb(0, OFS_STATUS, 0);
        `CHK(q, 32'h1)
        $display("abort test done");
        summarize;
    end
endmodule
`default_nettype wire
